// >>> rtl/cmsp_pkg.sv
// Purpose: shared constants and types for the chip mode, security and power control block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   register offsets are byte addresses on the plain register port
package cmsp_pkg;

    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned ADDR_W          = 4;
    localparam int unsigned DATA_W          = 8;

    // register offsets
    localparam logic [3:0] MODE_REG_ADDR    = 4'h0;
    localparam logic [3:0] MISC_REG_ADDR    = 4'h1;
    localparam logic [3:0] SEC_REG_ADDR     = 4'h2;
    localparam logic [3:0] POWER_REG_ADDR   = 4'h3;
    localparam logic [3:0] STATUS_REG_ADDR  = 4'h4;

    // field positions
    localparam int unsigned MODE_LSB        = 0;
    localparam int unsigned MISC_FLASH_BIT  = 0;
    localparam int unsigned SEC_PROG_BIT    = 0;
    localparam int unsigned SEC_ERASE_BIT   = 1;
    localparam int unsigned SEC_BLANK_BIT   = 2;
    localparam int unsigned SEC_UNLOCK_BIT  = 3;
    localparam int unsigned SEC_DBGCMD_BIT  = 4;
    localparam int unsigned POWER_PSEUDO_BIT = 0;

    // values after reset
    localparam logic [2:0] MODE_RESET       = 3'h0;
    localparam logic       SEC_NV_RESET     = 1'b0;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // blank check length, in ns and in cycles
    localparam int unsigned BLANK_CHECK_NS     = 1000;
    localparam int unsigned BLANK_CHECK_CYCLES = (BLANK_CHECK_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  BLANK_CHECK_LAST   = 8'(BLANK_CHECK_CYCLES - 1);

    typedef enum logic [2:0] {
        CMSP_SPECIAL_SINGLE = 3'h0,
        CMSP_EMUL_NARROW    = 3'h1,
        CMSP_SPECIAL_TEST   = 3'h2,
        CMSP_EMUL_WIDE      = 3'h3,
        CMSP_NORMAL_SINGLE  = 3'h4,
        CMSP_NORMAL_NARROW  = 3'h5,
        CMSP_PERIPHERAL     = 3'h6,
        CMSP_NORMAL_WIDE    = 3'h7
    } cmsp_mode_t;

    typedef enum {
        CMSP_PWR_RUN,
        CMSP_PWR_WAIT,
        CMSP_PWR_PSEUDO,
        CMSP_PWR_STOP
    } cmsp_pwr_t;

    // strap pins sampled on the first edge after reset release
    typedef struct packed {
        logic mode_sel_c;
        logic mode_sel_b;
        logic mode_sel_a;
        logic flash_map_pin;
        logic osc_type_strap;
    } cmsp_strap_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmsp_req_t;

    // clock and power gating outputs
    typedef struct packed {
        logic osc_run;
        logic core_clk_en;
        logic periph_clk_en;
        logic tick_clk_en;
        logic cpu_bus_hold;
    } cmsp_pwr_out_t;

endpackage

// >>> rtl/cmsp_top.sv
// Purpose: chip mode, flash visibility, security and low-power sequencing
// Assumes: strap pins synchronous to ref_clk; reset synchronous, active high
// Notes:   registers sit on a plain strobe port with read data one cycle late
//
// Contract
// - latch the three mode-select pins into the mode bits at reset release.
// - latch the flash-map pin into the flash-visible bit at reset release.
// - flash visible in the memory map only while the flash-visible bit is 1.
// - mode bits show the active mode and allow limited software mode changes.
// - pattern 000 is special single-chip, flash visible, debug active at once.
// - pattern 001 is emulation narrow; flash visible when flash-map pin is 0.
// - pattern 010 is special test wide; flash never visible. Here the bit starts at 0, but a misc register write can set it.
// - pattern 011 is emulation wide; flash visible when flash-map pin is 0.
// - pattern 100 is normal single-chip; flash always visible. Here the bit starts at 1, but a misc register write can clear it.
// - pattern 101 is normal narrow; flash visible when flash-map pin is 1.
// - pattern 111 is normal wide; flash visible when flash-map pin is 1.
// - oscillator strap 1 selects Colpitts, 0 selects Pierce or external clock.
// - programmed security bits keep the part secured across resets and power cycles.
// - secured normal single-chip behaves normally but refuses all debug operations.
// - secured reset into expanded mode disables flash and blocks debug.
// - unsecuring needs a flash erase first, or a backdoor key access.
// - after erase, reset into special single-chip runs a blank check, then unlock.
// - a reset after erase but before reprogramming leaves the part secured.
// - full stop halts all clocks and oscillator; wake only by reset or interrupt.
// - pseudo stop keeps oscillator, tick and watchdog; other peripherals off.
// - wait stops the processor, holds its buses, keeps peripherals clocked.
`timescale 1ns/1ps

module cmsp_top (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // strap pins
    input  wire cmsp_pkg::cmsp_strap_t strap,
    // register port
    input  wire cmsp_pkg::cmsp_req_t   req,
    output logic [7:0]                rdata,
    // processor and flash events
    input  wire logic                 stop_instr,
    input  wire logic                 idle_instr,
    input  wire logic                 ext_irq,
    input  wire logic                 any_irq,
    input  wire logic                 nv_secure,
    input  wire logic                 flash_erased,
    input  wire logic                 backdoor_ok,
    input  wire logic                 debug_req,
    // configuration and gating outputs
    output cmsp_pkg::cmsp_mode_t      mode,
    output logic                      flash_visible_bit,
    output logic                      flash_in_map,
    output logic                      osc_colpitts,
    output logic                      secured,
    output logic                      debug_allowed,
    output logic                      debug_active,
    output logic                      blank_check_busy,
    output cmsp_pkg::cmsp_pwr_out_t   pwr
);

    // pattern to flash-visible value
    function automatic logic flash_vis_f(input logic [2:0] m, input logic map_pin);
        case (m)
            3'h0:    flash_vis_f = 1'b1;
            3'h1:    flash_vis_f = ~map_pin;
            3'h2:    flash_vis_f = 1'b0;
            3'h3:    flash_vis_f = ~map_pin;
            3'h4:    flash_vis_f = 1'b1;
            3'h5:    flash_vis_f = map_pin;
            3'h6:    flash_vis_f = 1'b1;
            default: flash_vis_f = map_pin;
        endcase
    endfunction

    function automatic logic expanded_f(input logic [2:0] m);
        expanded_f = (m != 3'h0) && (m != 3'h4);
    endfunction

    logic        in_reset_q;
    logic [2:0]  mode_q;
    logic        vis_q;
    logic        osc_q;
    logic        sec_q;
    logic        erased_q;
    logic        unlock_q;
    logic        blank_ok_q;
    logic        blank_busy_q;
    logic [7:0]  blank_cnt_q;
    logic        dbg_act_q;
    logic        pseudo_sel_q;
    logic [7:0]  rdata_q;
    cmsp_pkg::cmsp_pwr_t   pwr_q;
    cmsp_pkg::cmsp_pwr_out_t pwr_out_q;
    logic        release_w;
    logic [2:0]  strap_mode_w;

    assign strap_mode_w = {strap.mode_sel_c, strap.mode_sel_b, strap.mode_sel_a};
    // first cycle out of reset; straps are read only here, later pin moves are ignored
    assign release_w    = in_reset_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            in_reset_q <= 1'b1;
        end else begin
            in_reset_q <= 1'b0;
        end
    end

    // mode bits: straps at release, then limited software writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= cmsp_pkg::MODE_RESET;
        end else if (release_w) begin
            mode_q <= strap_mode_w;
        end else if (req.wr && req.addr == cmsp_pkg::MODE_REG_ADDR) begin
            // only special and emulation modes (mode bit 2 clear) may switch, never into peripheral mode
            if (!mode_q[2] && req.wdata[2:0] != 3'h6) begin
                mode_q <= req.wdata[2:0];
            end
        end
    end

    // flash visibility: strap at release, then software writes to the misc register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vis_q <= 1'b0;
        end else if (release_w) begin
            vis_q <= flash_vis_f(strap_mode_w, strap.flash_map_pin);
        end else if (req.wr && req.addr == cmsp_pkg::MISC_REG_ADDR) begin
            vis_q <= req.wdata[cmsp_pkg::MISC_FLASH_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            osc_q <= 1'b0;
        end else if (release_w) begin
            osc_q <= strap.osc_type_strap;
        end
    end

    // security: reloaded from the non-volatile bit on every reset release
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sec_q <= 1'b1;
        end else if (release_w) begin
            sec_q <= nv_secure;
        end else if (backdoor_ok) begin
            sec_q <= 1'b0;
        end else if (unlock_q) begin
            sec_q <= 1'b0;
        end
    end

    // erase seen; volatile, so a reset before reprogramming re-secures
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            erased_q <= 1'b0;
        end else if (flash_erased) begin
            erased_q <= 1'b1;
        end
    end

    // blank check runs in special single-chip after release when secured
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            blank_busy_q <= 1'b0;
            blank_cnt_q  <= 8'h00;
            blank_ok_q   <= 1'b0;
        end else if (release_w) begin
            blank_busy_q <= (strap_mode_w == 3'h0) && nv_secure;
            blank_cnt_q  <= 8'h00;
            blank_ok_q   <= 1'b0;
        end else if (blank_busy_q) begin
            if (blank_cnt_q == cmsp_pkg::BLANK_CHECK_LAST) begin
                blank_busy_q <= 1'b0;
                blank_ok_q   <= flash_erased || erased_q;
            end else begin
                blank_cnt_q <= blank_cnt_q + 8'h01;
            end
        end
    end

    // unlock write is honoured only after a passing blank check
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            unlock_q <= 1'b0;
        end else begin
            unlock_q <= req.wr && req.addr == cmsp_pkg::SEC_REG_ADDR
                        && req.wdata[cmsp_pkg::SEC_UNLOCK_BIT] && blank_ok_q;
        end
    end

    // debug: active at once in special single-chip, else on a serial command
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dbg_act_q <= 1'b0;
        end else if (release_w) begin
            dbg_act_q <= (strap_mode_w == 3'h0);
        end else if (debug_req) begin
            dbg_act_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pseudo_sel_q <= 1'b0;
        end else if (req.wr && req.addr == cmsp_pkg::POWER_REG_ADDR) begin
            pseudo_sel_q <= req.wdata[cmsp_pkg::POWER_PSEUDO_BIT];
        end
    end

    // low-power sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pwr_q <= cmsp_pkg::CMSP_PWR_RUN;
        end else begin
            case (pwr_q)
                cmsp_pkg::CMSP_PWR_RUN: begin
                    if (stop_instr) begin
                        pwr_q <= pseudo_sel_q ? cmsp_pkg::CMSP_PWR_PSEUDO
                                              : cmsp_pkg::CMSP_PWR_STOP;
                    end else if (idle_instr) begin
                        pwr_q <= cmsp_pkg::CMSP_PWR_WAIT;
                    end
                end
                cmsp_pkg::CMSP_PWR_WAIT: begin
                    if (any_irq) begin
                        pwr_q <= cmsp_pkg::CMSP_PWR_RUN;
                    end
                end
                cmsp_pkg::CMSP_PWR_PSEUDO: begin
                    if (any_irq) begin
                        pwr_q <= cmsp_pkg::CMSP_PWR_RUN;
                    end
                end
                default: begin
                    // no clock runs, so only an external interrupt can wake
                    if (ext_irq) begin
                        pwr_q <= cmsp_pkg::CMSP_PWR_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pwr_out_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            case (pwr_q)
                cmsp_pkg::CMSP_PWR_WAIT:
                    pwr_out_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
                cmsp_pkg::CMSP_PWR_PSEUDO:
                    pwr_out_q <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
                cmsp_pkg::CMSP_PWR_STOP:
                    pwr_out_q <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
                default:
                    pwr_out_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            endcase
        end
    end

    // register reads
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= cmsp_pkg::READ_ZERO;
        end else if (req.rd) begin
            if (req.addr == cmsp_pkg::MODE_REG_ADDR) begin
                rdata_q <= {5'h00, mode_q};
            end else if (req.addr == cmsp_pkg::MISC_REG_ADDR) begin
                rdata_q <= {7'h00, vis_q};
            end else if (req.addr == cmsp_pkg::SEC_REG_ADDR) begin
                rdata_q <= {3'h0, dbg_act_q, 1'b0, blank_ok_q, erased_q, sec_q};
            end else if (req.addr == cmsp_pkg::POWER_REG_ADDR) begin
                rdata_q <= {7'h00, pseudo_sel_q};
            end else if (req.addr == cmsp_pkg::STATUS_REG_ADDR) begin
                rdata_q <= {6'h00, blank_busy_q, osc_q};
            end else begin
                rdata_q <= cmsp_pkg::READ_ZERO;
            end
        end else begin
            rdata_q <= cmsp_pkg::READ_ZERO;
        end
    end

    // registered outputs; security gating is folded in here
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode              <= cmsp_pkg::CMSP_SPECIAL_SINGLE;
            flash_visible_bit <= 1'b0;
            flash_in_map      <= 1'b0;
            osc_colpitts      <= 1'b0;
            secured           <= 1'b1;
            debug_allowed     <= 1'b0;
            debug_active      <= 1'b0;
            blank_check_busy  <= 1'b0;
            pwr               <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            mode              <= cmsp_pkg::cmsp_mode_t'(mode_q);
            flash_visible_bit <= vis_q;
            flash_in_map      <= vis_q && !(sec_q && expanded_f(mode_q));
            osc_colpitts      <= osc_q;
            secured           <= sec_q;
            debug_allowed     <= !sec_q;
            debug_active      <= dbg_act_q && !sec_q;
            blank_check_busy  <= blank_busy_q;
            pwr               <= pwr_out_q;
        end
    end

    assign rdata = rdata_q;

endmodule // cmsp_top

// >>> tb/cmsp_top_monitor.sv
// Purpose: port-level checks for the mode, security and power block
// Assumes: one clock, synchronous active-high reset
// Notes:   power outputs follow an event by three cycles
`timescale 1ns/1ps

module cmsp_top_monitor (
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    reset,
    // requests and events
    input wire cmsp_pkg::cmsp_req_t     req,
    input wire logic                    stop_instr,
    input wire logic                    idle_instr,
    input wire logic                    ext_irq,
    input wire logic                    any_irq,
    // status
    input wire cmsp_pkg::cmsp_mode_t    mode,
    input wire logic                    flash_visible_bit,
    input wire logic                    flash_in_map,
    input wire logic                    secured,
    input wire logic                    debug_allowed,
    input wire logic                    debug_active,
    input wire logic                    blank_check_busy,
    input wire cmsp_pkg::cmsp_pwr_out_t pwr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic run_w;
    assign run_w = (pwr == 5'b11110);

    dbg_gate_a: assert property (debug_allowed == !secured)
        else $error("debug allowed while secured");
    dbg_block_a: assert property (secured |-> !debug_active)
        else $error("debug active while secured");
    map_gate_a: assert property (flash_in_map |-> flash_visible_bit || $past(flash_visible_bit))
        else $error("flash mapped while not visible");
    secure_exp_a: assert property ((secured && !(mode inside {3'h0, 3'h4, 3'h6}))[*3]
        |-> !flash_in_map) else $error("flash mapped in secured expanded mode");
    // settle margin of four cycles covers the strap sample and a register write landing
    strap_hold_a: assert property ((!req.wr)[*4]
        |=> $stable(mode) && $stable(flash_visible_bit)) else $error("mode moved without a write");
    // outputs trail the event by three sampled edges, so two cycles of history are excluded
    stop_off_a: assert property ((run_w && stop_instr && !any_irq && !ext_irq
        && !$past(idle_instr) && !$past(stop_instr) && !$past(idle_instr, 2)
        && !$past(stop_instr, 2)) ##1 (!any_irq && !ext_irq)
        |=> ##1 !pwr.core_clk_en && !pwr.periph_clk_en) else $error("stop left clocks running");
    stop_hold_a: assert property ((!pwr.osc_run && !ext_irq && !$past(ext_irq)
        && !$past(ext_irq, 2)) ##1 !ext_irq |=> !pwr.osc_run)
        else $error("stop woke without external interrupt");
    pseudo_osc_a: assert property (!pwr.periph_clk_en && pwr.tick_clk_en
        |-> pwr.osc_run && !pwr.core_clk_en) else $error("pseudo stop lost oscillator");
    wait_on_a: assert property ((run_w && idle_instr && !stop_instr && !any_irq
        && !$past(stop_instr) && !$past(idle_instr) && !$past(stop_instr, 2)
        && !$past(idle_instr, 2)) ##1 !any_irq
        |=> ##1 pwr.periph_clk_en && pwr.cpu_bus_hold) else $error("wait stopped peripherals");

    cover property (pwr == 5'b00001);
    cover property (!pwr.periph_clk_en && pwr.tick_clk_en);
    cover property ($fell(blank_check_busy));
endmodule // cmsp_top_monitor

bind cmsp_top cmsp_top_monitor u_mon (
    .ref_clk(ref_clk), .reset(reset), .req(req), .stop_instr(stop_instr),
    .idle_instr(idle_instr), .ext_irq(ext_irq), .any_irq(any_irq), .mode(mode),
    .flash_visible_bit(flash_visible_bit), .flash_in_map(flash_in_map), .secured(secured),
    .debug_allowed(debug_allowed), .debug_active(debug_active),
    .blank_check_busy(blank_check_busy), .pwr(pwr)
);

// >>> tb/cmsp_strap_model.sv
// Purpose: board strap pins around reset
// Assumes: pins shared with other uses after reset
// Notes:   drives the inverse after release so a late sample shows
`timescale 1ns/1ps

module cmsp_strap_model (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // wanted strap levels
    input  wire cmsp_pkg::cmsp_strap_t cfg,
    // pins
    output cmsp_pkg::cmsp_strap_t      strap
);
    logic [1:0] held_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_q <= 2'h0;
        end else if (held_q != 2'h3) begin
            held_q <= held_q + 2'h1;
        end
    end
    assign strap = (reset || held_q < 2'h2) ? cfg : ~cfg;
endmodule // cmsp_strap_model

// >>> tb/cmsp_top_bench.sv
// Purpose: self-checking bench for the mode, security and power block
// Assumes: fixed seed, strap model on the pins
// Notes:   the peripheral strap pattern is never driven
`timescale 1ns/1ps

module cmsp_top_bench;
    logic                    ref_clk;
    logic                    reset;
    cmsp_pkg::cmsp_strap_t   cfg;
    cmsp_pkg::cmsp_strap_t   strap;
    cmsp_pkg::cmsp_req_t     req;
    logic [7:0]              rdata;
    logic [5:0]              ev;
    logic                    nv_sec;
    logic                    erased;
    cmsp_pkg::cmsp_mode_t    mode;
    logic                    vis, in_map, osc, sec, dbg_ok, dbg_act, busy;
    cmsp_pkg::cmsp_pwr_out_t pwr;
    int                      n_mismatch, samples_checked, seed, i;
    logic [7:0]              d;
    logic [31:0]             r;
    logic                    e;

    cmsp_strap_model u_pins (.ref_clk(ref_clk), .reset(reset), .cfg(cfg), .strap(strap));
    cmsp_top u_dut (.ref_clk(ref_clk), .reset(reset), .strap(strap), .req(req), .rdata(rdata),
        .stop_instr(ev[0]), .idle_instr(ev[1]), .ext_irq(ev[2]), .any_irq(ev[3]),
        .nv_secure(nv_sec), .flash_erased(erased), .backdoor_ok(ev[5]), .debug_req(ev[4]),
        .mode(mode), .flash_visible_bit(vis), .flash_in_map(in_map), .osc_colpitts(osc),
        .secured(sec), .debug_allowed(dbg_ok), .debug_active(dbg_act),
        .blank_check_busy(busy), .pwr(pwr));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // one-cycle event: 0 stop, 1 idle, 2 ext irq, 3 any irq, 4 debug cmd, 5 backdoor
    task automatic pulse(input int s);
        @(posedge ref_clk);
        ev <= 6'h01 << s;
        @(posedge ref_clk);
        ev <= 6'h00;
        tick(2);
    endtask

    task automatic do_reset(input logic [4:0] c, input logic s);
        @(posedge ref_clk);
        reset <= 1'b1;
        cfg <= c;
        nv_sec <= s;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        tick(4);
    endtask

    function automatic logic exp_vis(input logic [2:0] m, input logic map);
        case (m)
            3'h1, 3'h3: return !map;
            3'h2: return 1'b0;
            3'h5, 3'h7: return map;
            default: return 1'b1;
        endcase
    endfunction

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        seed = 32'h2455b805;
        reset = 1'b1;
        cfg = '0;
        req = '0;
        ev = 6'h00;
        nv_sec = 1'b0;
        erased = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (2) @(posedge ref_clk);
        // every pattern except 110 with both flash-map levels, random oscillator strap
        for (int k = 0; k < 16; k++) begin
            if (k[2:0] == 3'h6) continue;
            r = $random(seed);
            e = exp_vis(k[2:0], k[3]);
            do_reset({k[2:0], k[3], r[0]}, 1'b0);
            chk({5'h0, mode}, {5'h0, k[2:0]});
            chk({7'h0, vis}, {7'h0, e});
            chk({7'h0, in_map}, {7'h0, e});
            chk({7'h0, osc}, {7'h0, r[0]});
            chk({7'h0, dbg_act}, {7'h0, k[2:0] == 3'h0});
            rd(cmsp_pkg::MISC_REG_ADDR, d);
            chk(d, {7'h0, e});
            pulse(4);
            chk({7'h0, dbg_act}, 8'h01);
        end
        do_reset(5'h00, 1'b0);
        wr(cmsp_pkg::MODE_REG_ADDR, 8'h06);
        tick(2);
        chk({5'h0, mode}, 8'h00);
        wr(cmsp_pkg::MODE_REG_ADDR, 8'h05);
        tick(2);
        chk({5'h0, mode}, 8'h05);
        wr(cmsp_pkg::MODE_REG_ADDR, 8'h00);
        rd(cmsp_pkg::MODE_REG_ADDR, d);
        chk(d, 8'h05);
        rd(4'hf, d);
        chk(d, 8'h00);
        pulse(4);
        chk({7'h0, dbg_act}, 8'h01);
        // full stop ignores ordinary interrupts, pseudo stop and wait do not
        wr(cmsp_pkg::POWER_REG_ADDR, 8'h00);
        pulse(0);
        chk({3'h0, pwr}, 8'h01);
        pulse(3);
        chk({3'h0, pwr}, 8'h01);
        pulse(2);
        chk({3'h0, pwr}, 8'h1e);
        wr(cmsp_pkg::POWER_REG_ADDR, 8'h01);
        pulse(0);
        chk({5'h0, pwr.osc_run, pwr.periph_clk_en, pwr.tick_clk_en}, 8'h05);
        pulse(3);
        chk({3'h0, pwr}, 8'h1e);
        pulse(1);
        chk({5'h0, pwr.osc_run, pwr.periph_clk_en, pwr.cpu_bus_hold}, 8'h07);
        pulse(3);
        chk({3'h0, pwr}, 8'h1e);
        // secured part
        do_reset(5'h1e, 1'b1);
        chk({6'h0, sec, in_map}, 8'h02);
        pulse(4);
        chk({6'h0, dbg_ok, dbg_act}, 8'h00);
        do_reset(5'h12, 1'b1);
        pulse(4);
        chk({5'h0, in_map, dbg_ok, dbg_act}, 8'h04);
        pulse(5);
        chk({7'h0, sec}, 8'h00);
        @(posedge ref_clk);
        erased <= 1'b1;
        do_reset(5'h00, 1'b1);
        chk({6'h0, busy, sec}, 8'h03);
        for (i = 0; i < 300 && busy !== 1'b0; i++) tick(1);
        if (busy !== 1'b0) begin
            n_mismatch++;
        end else begin
            // unlock lands on the edge that samples the write, sec_q one edge later, the secured output one more
            wr(cmsp_pkg::SEC_REG_ADDR, 8'h08);
            tick(2);
            chk({7'h0, sec}, 8'h00);
            @(posedge ref_clk);
            erased <= 1'b0;
            do_reset(5'h00, 1'b1);
            wr(cmsp_pkg::SEC_REG_ADDR, 8'h08);
            tick(2);
            chk({7'h0, sec}, 8'h01);
        end
        final_report();
    end
endmodule // cmsp_top_bench
